// File: rtl/servo_sel_defines.vh
// Constants for the servo output selector
`ifndef SERVO_SEL_DEFINES_VH
`define SERVO_SEL_DEFINES_VH
// Clock rate
`define SOS_CLK_HZ        250000000
// Register byte offsets
`define SOS_REG_CTRL      12'h000
`define SOS_REG_CFG       12'h004
`define SOS_REG_TARGET    12'h008
`define SOS_REG_LIMIT     12'h00C
`define SOS_REG_PRESET    12'h010
`define SOS_REG_POSITION  12'h014
`define SOS_REG_STATUS    12'h018
`define SOS_REG_CAL       12'h01C
// Control fields
`define SOS_CTRL_MANUAL   0
`define SOS_CTRL_IDLE     1
`define SOS_CTRL_ERROR    2
`define SOS_CTRL_SENSE    3
`define SOS_CTRL_KEY_OPEN 4
`define SOS_CTRL_KEY_CLS  5
// Action encodings (stop, close, open)
`define SOS_ACT_STOP      2'h0
`define SOS_ACT_CLOSE     2'h1
`define SOS_ACT_OPEN      2'h2
// Source encodings
`define SOS_SRC_MANUAL    3'h0
`define SOS_SRC_FAULT     3'h1
`define SOS_SRC_IDLE      3'h2
`define SOS_SRC_PRESET    3'h3
`define SOS_SRC_ERROR     3'h4
`define SOS_SRC_PID       3'h5
`define SOS_SRC_CAL       3'h6
// Percent scale: 0.1 % units, 1000 = 100 %
`define SOS_FULL          12'h3E8
`define SOS_DB_RESET      12'h014
`define SOS_DB_MIN        12'h002
`define SOS_DB_SMALL      12'h00C
`define SOS_HYS_SMALL     12'h003
`define SOS_CAL_GAP       12'h064
`define SOS_LIM_HI_RESET  12'h3E8
// End-of-range pulse timing
`define SOS_PULSE_SEC     30
`define SOS_PULSE_PCT     5
`define SOS_PCT_DIV       100
`define SOS_TRAVEL_RESET  16'h003C
`endif

// File: rtl/servo_sel.v
// Servo output selector: source priority, dead band and end pulses
//
// Notes on behaviour
// - Priority: manual, calibration, fault, idle, preset, error, PID
// - Manual entry allowed regardless of idle hold
// - Manual drives open/close directly from keys
// - With sensing, contacts pick preset slots 1-7
// - Without sensing, slots stop/close/open/stop
// - No contact active means PID output drives
// - Limiter never touches manual or preset
// - Limiter on with sensing, off without
// - Drive only while error exceeds dead band
// - Low lead open: position <=0, open continuously
// - Wiper lead open: fault flag, fault action
// - High lead open: position >=100, close continuously
// - At 0% no sensing: close pulse each 30s
// - At 100% no sensing: open pulse periodically
// - Hysteresis is quarter of dead band
// - Dead band under 1.2%: hysteresis 0.3%
// - Dead band at minimum: hysteresis equals it
// - One dead band for both outputs, default 2.0%
// - Zero point calibration: close while down key
// - Span point calibration: open while up key
// - Flag both counts if span-zero gap small
// - Manual suspends preset, return restores it
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "servo_sel_defines.vh"
`default_nettype none
module sos_servo_sel #(
  parameter integer TICKS_PER_SEC = `SOS_CLK_HZ     // Clocks per second
) (
  input  wire        pclk,             // APB clock
  input  wire        presetn,          // Async reset, active low
  input  wire        psel,             // APB select
  input  wire        penable,          // APB enable
  input  wire        pwrite,           // APB direction
  input  wire [11:0] paddr,            // APB byte address
  input  wire [31:0] pwdata,           // APB write data
  output wire        pready,           // APB ready
  output reg  [31:0] prdata,           // APB read data
  output wire        pslverr,          // APB error
  input  wire        preset_select_in_a, // Preset contact, bit 0
  input  wire        preset_select_in_b, // Preset contact, bit 1
  input  wire        preset_select_in_c, // Preset contact, bit 2
  input  wire        pot_lead_low,     // Low lead open detect
  input  wire        pot_lead_wiper,   // Wiper lead open detect
  input  wire        pot_lead_high,    // High lead open detect
  input  wire        key_open,         // Up (open) key held
  input  wire        key_close,        // Down (close) key held
  output reg         drive_open,       // Open output to motor
  output reg         drive_close,      // Close output to motor
  output reg  [2:0]  active_source     // Winning source code
);
  // Long count constants; thirty seconds at the full clock rate needs more
  // than 32 bits, so the product is formed at 40 bits on purpose
  localparam [39:0]  PER_CNT      = TICKS_PER_SEC * 40'h1 * `SOS_PULSE_SEC;

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage input synchronisers
  reg [7:0] sync1_ff;
  reg [7:0] sync2_ff;
  reg [7:0] sync3_ff;
  reg [7:0] in_ff;
  wire [7:0] raw_in = {key_close, key_open, pot_lead_high, pot_lead_wiper,
                       pot_lead_low, preset_select_in_c, preset_select_in_b,
                       preset_select_in_a};
  integer i;
  // Change counts once stages two and three agree; a pin that bounces
  // between samples keeps its last settled level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
      sync3_ff <= 8'h00;
      in_ff    <= 8'h00;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      for (i = 0; i < 8; i = i + 1) begin
        if (sync2_ff[i] == sync3_ff[i]) begin
          in_ff[i] <= sync3_ff[i];
        end
      end
    end
  end
  wire [2:0] preset_in = in_ff[2:0];
  wire       lead_low  = in_ff[3];
  wire       lead_wip  = in_ff[4];
  wire       lead_high = in_ff[5];
  wire       k_open    = in_ff[6];
  wire       k_close   = in_ff[7];

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [5:0]  ctrl_ff;           // Manual, idle, error, sensing, keys
  reg  [11:0] deadzone_width_ff; // Dead band in 0.1 %
  reg  [1:0]  fault_act_ff;      // Sensor fault action
  reg  [1:0]  idle_act_ff;       // Idle hold action
  reg  [1:0]  err_act_ff;        // Error action
  reg  [15:0] travel_ff;         // Motor travel time, seconds
  reg  [11:0] control_output_value_ff; // PID output
  reg  [11:0] lim_lo_ff;         // Limiter low
  reg  [11:0] lim_hi_ff;         // Limiter high
  reg  [11:0] position_ff;       // Measured position
  reg  [11:0] zero_cnt_ff;       // Calibration zero count
  reg  [11:0] span_cnt_ff;       // Calibration span count
  reg  [3:0]  cal_ff;            // Method, run, cursor span, active
  reg  [83:0] slot_ff;           // Preset slot targets 1..7
  wire        wr = psel & penable & pwrite;

  // Function: mapped address check
  function mapped;
    input [11:0] a;
    begin
      mapped = (a <= `SOS_REG_CAL) && (a[1:0] == 2'h0);
    end
  endfunction
  // Zero wait states: every access ends in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);

  // Register writes; calibration starts on confirm with manual method
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff                 <= 6'h00;
      deadzone_width_ff       <= `SOS_DB_RESET;
      fault_act_ff            <= `SOS_ACT_STOP;
      idle_act_ff             <= `SOS_ACT_STOP;
      err_act_ff              <= `SOS_ACT_STOP;
      travel_ff               <= `SOS_TRAVEL_RESET;
      control_output_value_ff <= 12'h000;
      lim_lo_ff               <= 12'h000;
      lim_hi_ff               <= `SOS_LIM_HI_RESET;
      position_ff             <= 12'h000;
      zero_cnt_ff             <= 12'h000;
      span_cnt_ff             <= 12'h000;
      cal_ff                  <= 4'h0;
      slot_ff                 <= 84'h0;
    end else if (wr) begin
      // Writes to read-only or unmapped offsets fall to the default
      case (paddr)
        `SOS_REG_CTRL:     ctrl_ff <= pwdata[5:0];
        `SOS_REG_CFG: begin
          deadzone_width_ff <= pwdata[11:0];
          fault_act_ff      <= pwdata[13:12];
          idle_act_ff       <= pwdata[15:14];
          err_act_ff        <= pwdata[17:16];
          travel_ff         <= {4'h0, pwdata[29:18]};
        end
        `SOS_REG_TARGET:   control_output_value_ff <= pwdata[11:0];
        `SOS_REG_LIMIT: begin
          lim_lo_ff <= pwdata[11:0];
          lim_hi_ff <= pwdata[27:16];
        end
        `SOS_REG_PRESET:
          slot_ff[pwdata[30:28]*12 +: 12] <= pwdata[11:0];
        `SOS_REG_POSITION: position_ff <= pwdata[11:0];
        `SOS_REG_CAL: begin
          if (pwdata[3] && pwdata[0] && pwdata[1]) begin
            cal_ff <= {1'b1, pwdata[2:0]};
          end else begin
            cal_ff <= {1'b0, pwdata[2:0]};
          end
          if (pwdata[4]) begin
            if (pwdata[2]) span_cnt_ff <= position_ff;
            else           zero_cnt_ff <= position_ff;
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hysteresis from dead band; settings below the minimum would make the
  // release threshold wrap, so they are outside the usable range
  reg [11:0] hys;
  always @* begin
    if (deadzone_width_ff == `SOS_DB_MIN)        hys = `SOS_DB_MIN;
    else if (deadzone_width_ff < `SOS_DB_SMALL)  hys = `SOS_HYS_SMALL;
    else                                         hys = {2'h0, deadzone_width_ff[11:2]};
  end

  // PID target with limiter only when sensing
  // A crossed limit pair pins the target to the high limit
  wire       sense = ctrl_ff[`SOS_CTRL_SENSE];
  reg [11:0] pid_tgt;
  always @* begin
    pid_tgt = control_output_value_ff;
    if (sense) begin
      if (pid_tgt < lim_lo_ff) pid_tgt = lim_lo_ff;
      if (pid_tgt > lim_hi_ff) pid_tgt = lim_hi_ff;
    end
  end

  // Function: dead-band servo decision with hysteresis hold
  function [1:0] servo;
    input [11:0] tgt;
    input [11:0] pos;
    input [1:0]  prev;
    input [11:0] db;
    input [11:0] hy;
    reg   [12:0] thr;
    begin
      thr = (prev == `SOS_ACT_STOP) ? {1'b0, db} : {1'b0, db} - {1'b0, hy};
      if ({1'b0, tgt} > {1'b0, pos} + thr)      servo = `SOS_ACT_OPEN;
      else if ({1'b0, pos} > {1'b0, tgt} + thr) servo = `SOS_ACT_CLOSE;
      else                                      servo = `SOS_ACT_STOP;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // End-of-range pulses without sensing
  // Counters are 40 bits: a thirty-second period and a long travel time at
  // the full clock rate both overflow 32 bits. The period counter keeps
  // running when the output moves from one end straight to the other.
  reg  [39:0] per_ff;
  reg  [39:0] pw_ff;
  wire [39:0] pulse_len = (({24'h0, travel_ff} * `SOS_PULSE_PCT) / `SOS_PCT_DIV) *
                          TICKS_PER_SEC;
  wire        at_zero = (control_output_value_ff == 12'h000);
  wire        at_full = (control_output_value_ff >= `SOS_FULL);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_ff <= 40'h0;
      pw_ff  <= 40'h0;
    end else if (sense || !(at_zero || at_full)) begin
      per_ff <= 40'h0;
      pw_ff  <= 40'h0;
    end else if (per_ff >= PER_CNT - 40'h1) begin
      per_ff <= 40'h0;
      pw_ff  <= (pulse_len == 40'h0) ? 40'h1 : pulse_len;
    end else begin
      per_ff <= per_ff + 40'h1;
      if (pw_ff != 40'h0) pw_ff <= pw_ff - 40'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection and drive, every cycle
  // Calibration sits just below manual so the operator keys always win
  reg  [1:0] act;
  reg  [2:0] src;
  reg  [1:0] prev_ff;
  wire [2:0] slot_idx = preset_in - 3'h1;
  wire       manual   = ctrl_ff[`SOS_CTRL_MANUAL]; // Idle hold not checked
  always @* begin
    src = `SOS_SRC_PID;
    act = `SOS_ACT_STOP;
    if (manual) begin
      src = `SOS_SRC_MANUAL;
      if (k_open || ctrl_ff[`SOS_CTRL_KEY_OPEN])      act = `SOS_ACT_OPEN;
      else if (k_close || ctrl_ff[`SOS_CTRL_KEY_CLS]) act = `SOS_ACT_CLOSE;
    end else if (cal_ff[3]) begin
      src = `SOS_SRC_CAL;
      if (cal_ff[2] && k_open)        act = `SOS_ACT_OPEN;
      else if (!cal_ff[2] && k_close) act = `SOS_ACT_CLOSE;
    end else if (sense && lead_wip) begin
      src = `SOS_SRC_FAULT;
      act = fault_act_ff;
    end else if (sense && lead_low) begin
      src = `SOS_SRC_FAULT;
      act = `SOS_ACT_OPEN;
    end else if (sense && lead_high) begin
      src = `SOS_SRC_FAULT;
      act = `SOS_ACT_CLOSE;
    end else if (ctrl_ff[`SOS_CTRL_IDLE]) begin
      src = `SOS_SRC_IDLE;
      act = idle_act_ff;
    end else if (preset_in != 3'h0) begin
      src = `SOS_SRC_PRESET;
      if (sense) begin
        act = servo(slot_ff[slot_idx*12 +: 12], position_ff, prev_ff,
                    deadzone_width_ff, hys);
      end else begin
        case (preset_in)
          3'h2:    act = `SOS_ACT_CLOSE;
          3'h3:    act = `SOS_ACT_OPEN;
          default: act = `SOS_ACT_STOP;
        endcase
      end
    end else if (ctrl_ff[`SOS_CTRL_ERROR]) begin
      src = `SOS_SRC_ERROR;
      act = err_act_ff;
    end else if (sense) begin
      act = servo(pid_tgt, position_ff, prev_ff, deadzone_width_ff, hys);
    end else if (pw_ff != 40'h0) begin
      act = at_zero ? `SOS_ACT_CLOSE : `SOS_ACT_OPEN;
    end
  end

  // Registered outputs; the previous action feeds the hysteresis, so a
  // running motor is released later than an idle one is started
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff       <= `SOS_ACT_STOP;
      drive_open    <= 1'b0;
      drive_close   <= 1'b0;
      active_source <= `SOS_SRC_PID;
    end else begin
      prev_ff       <= act;
      drive_open    <= (act == `SOS_ACT_OPEN);
      drive_close   <= (act == `SOS_ACT_CLOSE);
      active_source <= src;
    end
  end

  // Narrow calibration flag
  wire cal_warn = (span_cnt_ff <= zero_cnt_ff) ||
                  ((span_cnt_ff - zero_cnt_ff) < `SOS_CAL_GAP);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux over the register set except the preset slots, which read as zero
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0;
    case (paddr)
      `SOS_REG_CTRL:     rd_mux = {26'h0, ctrl_ff};
      `SOS_REG_CFG:      rd_mux = {2'h0, travel_ff[11:0], err_act_ff, idle_act_ff,
                                   fault_act_ff, deadzone_width_ff};
      `SOS_REG_TARGET:   rd_mux = {20'h0, control_output_value_ff};
      `SOS_REG_LIMIT:    rd_mux = {4'h0, lim_hi_ff, 4'h0, lim_lo_ff};
      `SOS_REG_POSITION: rd_mux = {20'h0, position_ff};
      `SOS_REG_STATUS:   rd_mux = {12'h0, cal_warn, lead_high, lead_wip, lead_low,
                                   hys, 1'b0, active_source};
      `SOS_REG_CAL:      rd_mux = {4'h0, span_cnt_ff, zero_cnt_ff, cal_ff};
      default:           rd_mux = 32'h0;
    endcase
  end

  // Read data is captured on the setup edge so that it stands in flops
  // through the access cycle, where the master takes it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end
endmodule
`default_nettype wire

// File: dv/sos_checker.sv
// Assertion checker for the servo output selector
`timescale 1ns/1ps
`default_nettype none
module sos_checker (
  input wire logic       pclk,               // Clock
  input wire logic       presetn,            // Reset
  input wire logic       preset_select_in_a, // Contact 0
  input wire logic       preset_select_in_b, // Contact 1
  input wire logic       preset_select_in_c, // Contact 2
  input wire logic       pot_lead_low,       // Low lead
  input wire logic       pot_lead_wiper,     // Wiper lead
  input wire logic       pot_lead_high,      // High lead
  input wire logic       key_open,           // Open key
  input wire logic       key_close,          // Close key
  input wire logic       drive_open,         // Open drive
  input wire logic       drive_close,        // Close drive
  input wire logic [2:0] active_source       // Source
);
  logic [3:0] lead_age_ff; // Clocks since a lead fault
  // Saturating age of the last lead fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lead_age_ff <= 4'hF;
    else if (pot_lead_low | pot_lead_wiper | pot_lead_high) lead_age_ff <= 4'h0;
    else if (lead_age_ff != 4'hF) lead_age_ff <= lead_age_ff + 4'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Source code, drives and their causes
  property p_src; active_source <= 3'h6; endproperty
  a_src: assert property (p_src) else $error("bad source code");
  property p_excl; !(drive_open && drive_close); endproperty
  a_excl: assert property (p_excl) else $error("both drives on");
  property p_man_open;
    (active_source == 3'h0 && key_open && !key_close)[*8] |-> drive_open && !drive_close;
  endproperty
  a_man_open: assert property (p_man_open) else $error("manual open lost");
  property p_man_close;
    (active_source == 3'h0 && key_close && !key_open)[*8] |-> drive_close && !drive_open;
  endproperty
  a_man_close: assert property (p_man_close) else $error("manual close lost");
  property p_low;
    (active_source == 3'h1 && pot_lead_low && !pot_lead_wiper)[*8] |-> drive_open;
  endproperty
  a_low: assert property (p_low) else $error("low lead without open");
  property p_high;
    (active_source == 3'h1 && pot_lead_high && !pot_lead_low && !pot_lead_wiper)[*8]
      |-> drive_close;
  endproperty
  a_high: assert property (p_high) else $error("high lead without close");
  property p_fault; active_source == 3'h1 |-> lead_age_ff < 4'hA; endproperty
  a_fault: assert property (p_fault) else $error("fault source without lead");
  property p_no_pre;
    (!preset_select_in_a && !preset_select_in_b && !preset_select_in_c)[*8]
      |-> active_source != 3'h3;
  endproperty
  a_no_pre: assert property (p_no_pre) else $error("preset without contact");
endmodule
bind sos_servo_sel sos_checker i_chk (.pclk(pclk), .presetn(presetn),
  .preset_select_in_a(preset_select_in_a), .preset_select_in_b(preset_select_in_b),
  .preset_select_in_c(preset_select_in_c), .pot_lead_low(pot_lead_low),
  .pot_lead_wiper(pot_lead_wiper), .pot_lead_high(pot_lead_high), .key_open(key_open),
  .key_close(key_close), .drive_open(drive_open), .drive_close(drive_close),
  .active_source(active_source));
`default_nettype wire

// File: dv/sos_motor_model.sv
// Motor with limit switches and a three-lead position sensor
`timescale 1ns/1ps
`default_nettype none
module sos_motor_model (
  input  wire logic        pclk,           // Clock
  input  wire logic        presetn,        // Reset
  input  wire logic        drive_open,     // Open winding
  input  wire logic        drive_close,    // Close winding
  input  wire logic [2:0]  lead_brk,       // Broken lead: high, wiper, low
  output var  logic [11:0] pos,            // Position read, 0.1 % units
  output var  logic        pot_lead_low,   // Low lead open
  output var  logic        pot_lead_wiper, // Wiper lead open
  output var  logic        pot_lead_high   // High lead open
);
  logic [11:0] shaft_ff; // True shaft position
  logic        step_ff;  // Halves the speed
  // Shaft steps every second clock, stopped by the limit switches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shaft_ff <= 12'h1F4;
      step_ff  <= 1'b0;
    end else begin
      step_ff <= ~step_ff;
      if (step_ff && drive_open && shaft_ff < 12'h3E8) shaft_ff <= shaft_ff + 12'h001;
      else if (step_ff && drive_close && shaft_ff != 12'h000) shaft_ff <= shaft_ff - 12'h001;
    end
  end
  // A broken lead drags the reading to an end or leaves it floating
  always_comb begin
    pot_lead_low   = lead_brk[0];
    pot_lead_wiper = lead_brk[1];
    pot_lead_high  = lead_brk[2];
    if (lead_brk[0]) pos = 12'h000;
    else if (lead_brk[2]) pos = 12'h3E8;
    else if (lead_brk[1]) pos = shaft_ff ^ {12{step_ff}};
    else pos = shaft_ff;
  end
endmodule
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the servo output selector
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TPS = 100; // Short second keeps end pulses brief
  logic        pclk, presetn, psel, penable, pwrite, key_open, key_close, sl;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [2:0]  pre_code, lead_brk;
  logic [7:0]  v;
  wire  logic  pready, pslverr, drive_open, drive_close, lo, wi, hi;
  wire  logic [31:0] prdata;
  wire  logic [11:0] pos;
  wire  logic [2:0]  src;
  int          err_total, n_compared, seed, i, k, n_open, n_close;
  logic [11:0] dbs [5] = '{12'h002, 12'h00B, 12'h00C, 12'h028, 12'h014};

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  sos_servo_sel #(.TICKS_PER_SEC(TPS)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .preset_select_in_a(pre_code[0]),
    .preset_select_in_b(pre_code[1]), .preset_select_in_c(pre_code[2]), .pot_lead_low(lo),
    .pot_lead_wiper(wi), .pot_lead_high(hi), .key_open(key_open), .key_close(key_close),
    .drive_open(drive_open), .drive_close(drive_close), .active_source(src));
  sos_motor_model i_mot (.pclk(pclk), .presetn(presetn), .drive_open(drive_open),
    .drive_close(drive_close), .lead_brk(lead_brk), .pos(pos), .pot_lead_low(lo),
    .pot_lead_wiper(wi), .pot_lead_high(hi));

  // Expected source for {sense, error, idle, manual}, wiper fault and contacts
  function automatic logic [2:0] exp_src(input logic [3:0] c, input logic w,
                                         input logic [2:0] p);
    if (c[0]) return 3'h0;
    if (c[3] && w) return 3'h1;
    if (c[1]) return 3'h2;
    if (p != 3'h0) return 3'h3;
    if (c[2]) return 3'h4;
    return 3'h5;
  endfunction
  // Hysteresis from dead band
  function automatic logic [11:0] hys_of(input logic [11:0] db);
    if (db == 12'h002) return 12'h002;
    if (db < 12'h00C) return 12'h003;
    return db >> 2;
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task results;
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One APB transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wt;
    repeat (10) @(posedge pclk);
    @(negedge pclk);
  endtask
  // Feed the motor position until the drive stops
  task settle(input logic [11:0] tg);
    for (k = 0; k < 400; k++) begin
      apb(1'b1, 12'h014, {20'h0, pos});
      if (k > 3 && !drive_open && !drive_close) break;
    end
    @(negedge pclk);
    chk("stop", 0, {drive_open, drive_close});
    chk("near", 1, (pos + 12'd20 >= tg) && (pos <= tg + 12'd20));
  endtask
  task pulses;
    repeat (3100) @(posedge pclk);
    n_open = 0;
    n_close = 0;
    repeat (3000) begin
      @(negedge pclk);
      n_open += drive_open;
      n_close += drive_close;
    end
  endtask

  // Main sequence
  initial begin
    seed = 55;
    err_total = 0;
    n_compared = 0;
    {presetn, psel, penable, pwrite, key_open, key_close} = 6'h00;
    {paddr, pwdata, pre_code, lead_brk} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("src_rst", 5, src);
    apb(1'b0, 12'h004, 0);
    chk("cfg_rst", 32'h00F00014, rd);
    for (i = 0; i < 5; i++) begin
      apb(1'b1, 12'h004, 32'h00F00000 | dbs[i]);
      apb(1'b0, 12'h018, 0);
      chk("hys", hys_of(dbs[i]), rd[15:4]);
    end
    apb(1'b0, 12'h020, 0);
    chk("unmapped", 1, sl);
    for (i = 0; i < 40; i++) begin
      v = (i == 0) ? 8'h23 : (i == 1) ? 8'hFE : $random(seed);
      apb(1'b1, 12'h000, {28'h0, v[3:0]});
      lead_brk <= {1'b0, v[4], 1'b0};
      pre_code <= v[7:5];
      wt;
      chk("source", exp_src(v[3:0], v[4], v[7:5]), src);
    end
    apb(1'b1, 12'h000, 32'h9);
    lead_brk <= 3'h0;
    pre_code <= 3'h7;
    wt;
    chk("man_pre", 0, src);
    apb(1'b1, 12'h000, 32'h8);
    wt;
    chk("back_pre", 3, src);
    apb(1'b1, 12'h000, 32'h0);
    for (i = 1; i < 8; i++) begin
      @(posedge pclk) pre_code <= i[2:0];
      wt;
      chk("slot", (i == 2) ? 1 : (i == 3) ? 2 : 0, {drive_open, drive_close});
    end
    @(posedge pclk) pre_code <= 3'h0;
    apb(1'b1, 12'h000, 32'h1);
    key_open <= 1'b1;
    wt;
    chk("man_open", 2, {drive_open, drive_close});
    @(posedge pclk) key_open <= 1'b0;
    key_close <= 1'b1;
    wt;
    chk("man_close", 1, {drive_open, drive_close});
    apb(1'b1, 12'h000, 32'h8);
    apb(1'b1, 12'h01C, 32'hB);
    wt;
    chk("cal_zero", 1, {drive_open, drive_close});
    apb(1'b1, 12'h01C, 32'hF);
    key_close <= 1'b0;
    key_open <= 1'b1;
    wt;
    chk("cal_span", 2, {drive_open, drive_close});
    apb(1'b1, 12'h014, 32'h64);
    key_open <= 1'b0;
    apb(1'b1, 12'h01C, 32'h1B);
    apb(1'b1, 12'h014, 32'h96);
    apb(1'b1, 12'h01C, 32'h1F);
    apb(1'b0, 12'h018, 0);
    chk("narrow", 1, rd[19]);
    apb(1'b1, 12'h01C, 32'h0);
    lead_brk <= 3'h1;
    wt;
    chk("low_lead", 2, {drive_open, drive_close});
    @(posedge pclk) lead_brk <= 3'h4;
    wt;
    chk("high_lead", 1, {drive_open, drive_close});
    @(posedge pclk) lead_brk <= 3'h0;
    apb(1'b1, 12'h008, 32'h258);
    settle(12'h258);
    apb(1'b1, 12'h00C, 32'h032000C8);
    apb(1'b1, 12'h008, 32'h384);
    settle(12'h320);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    pulses;
    chk("pulse_close", 300, n_close);
    chk("pulse_cl_open", 0, n_open);
    apb(1'b1, 12'h008, 32'h3E8);
    pulses;
    chk("pulse_open", 300, n_open);
    chk("pulse_op_close", 0, n_close);
    results;
  end
  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge pclk);
    err_total++;
    results;
  end
endmodule
`default_nettype wire
